// ===== src/nfo_option_regs.sv
// framing option register bank: three 8-bit registers on an ahb-lite slave,
// decoded into per-frame settings for the receive and transmit framers; field detect and field-on count follow the live register
// assumes framer events are synchronous to i_clk_sys; single word transfers
//
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ns
`include "nfo_regs_map.svh"
module nfo_option_regs (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_set_default,
  input wire logic i_preset_valid,
  input wire logic i_preset_am,
  input wire nfo_pkg::nfo_evt_t i_evt,
  output nfo_pkg::nfo_cfg_t o_cfg
);
  import nfo_pkg::*;

  localparam int SNAP_W = 24;
  localparam logic [SNAP_W-1:0] SNAP_RST = {`NFO_RST_TYPE_B_F, `NFO_RST_STREAM, `NFO_RST_AUX};

  nfo_state_t st_reg;
  nfo_state_t st_next;
  logic [SNAP_W-1:0] tx_snap;
  logic [SNAP_W:0] rx_snap;
  logic [SNAP_W-1:0] live_bytes;
  logic rx_auto_skip;
  logic [1:0] rd_sel;
  logic rd_hit;

  // address decode shared by read and write phases
  function automatic logic [2:0] addr_decode(input logic [31:0] addr);
    logic [2:0] res;
    res = 3'h0;
    if (addr == 32'({`NFO_IDX_TYPE_B_F, 2'b00})) begin
      res = {1'b1, 2'h0};
    end else if (addr == 32'({`NFO_IDX_STREAM, 2'b00})) begin
      res = {1'b1, 2'h1};
    end else if (addr == 32'({`NFO_IDX_AUX, 2'b00})) begin
      res = {1'b1, 2'h2};
    end
    return res;
  endfunction

  // minimum turnaround in sub-carrier periods; unused codes flag bad
  function automatic logic [7:0] tr1_decode(input logic [1:0] code, input nfo_rate_t rate);
    logic [7:0] res;
    res = {1'b1, `NFO_TR1_LONG};
    case (code)
      2'h0: res = {1'b0, `NFO_TR1_LONG};
      2'h1: res = {1'b0, (rate == NFO_RATE_FC128) ? `NFO_TR1_MID : `NFO_TR1_SHORT};
      default: res = {1'b1, `NFO_TR1_LONG};
    endcase
    return res;
  endfunction

  // sub-carrier divisor; zero means an unused code
  function automatic logic [7:0] scf_decode(input logic [1:0] code, input logic bpsk);
    logic [7:0] res;
    res = 8'h00;
    if (bpsk) begin
      res = (code == 2'h0) ? 8'h10 : 8'h00;
    end else begin
      case (code)
        2'h0: res = 8'h40;
        2'h1: res = 8'h20;
        2'h2: res = 8'h10;
        default: res = 8'h00;
      endcase
    end
    return res;
  endfunction

  // tx modulator control period as fc divisor; zero means unused
  function automatic logic [7:0] stx_decode(input logic [2:0] code);
    logic [7:0] res;
    res = 8'h00;
    case (code)
      3'h0: res = 8'h80;
      3'h1: res = 8'h40;
      3'h2: res = 8'h20;
      3'h3: res = 8'h10;
      default: res = 8'h00;
    endcase
    return res;
  endfunction

  assign live_bytes = {st_reg.type_b_f_option_settings_reg, st_reg.stream_mode_definition_reg,
    st_reg.auxiliary_definition_reg};
  // auto crc skip is fixed for the whole frame, like the register bits
  assign rx_auto_skip = i_evt.reqa_wupa_sent | i_evt.anticoll_frame;

  // copies taken at frame start so mid-frame writes hit the next frame only
  nfo_frame_snap #(
    .WIDTH(SNAP_W),
    .RESET_VAL(SNAP_RST)
  ) u_tx_snap (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_load(i_evt.tx_frame_start),
    .i_data(live_bytes),
    .o_data(tx_snap)
  );

  nfo_frame_snap #(
    .WIDTH(SNAP_W + 1),
    .RESET_VAL({SNAP_RST, 1'b0})
  ) u_rx_snap (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_load(i_evt.rx_frame_start),
    .i_data({live_bytes, rx_auto_skip}),
    .o_data(rx_snap)
  );

  always_comb begin
    logic [7:0] bf_rx;
    logic [7:0] st_tx;
    logic [7:0] st_rx;
    logic [7:0] aux_tx;
    logic [7:0] aux_rx;
    logic [7:0] tr1;
    logic [7:0] wbyte;
    logic [2:0] dec;
    logic [7:0] sc_div;
    logic [7:0] tx_div;
    logic [1:0] scp;
    logic [1:0] pre;
    bf_rx = rx_snap[24:17];
    st_rx = rx_snap[16:9];
    aux_rx = rx_snap[8:1];
    st_tx = tx_snap[15:8];
    aux_tx = tx_snap[7:0];
    wbyte = i_hwdata[7:0];
    st_next = st_reg;

    // address phase: capture a valid transfer, prepare read data
    dec = addr_decode(i_haddr);
    rd_sel = dec[1:0];
    rd_hit = dec[2];
    st_next.wr_pend = 1'b0;
    st_next.ready = 1'b1;
    if (i_hsel && i_hready && i_htrans[1]) begin
      st_next.wr_pend = i_hwrite & rd_hit;
      st_next.wr_sel = rd_sel;
      st_next.rdata = 32'h0000_0000;
      if (!i_hwrite && rd_hit) begin
        case (rd_sel)
          2'h0: st_next.rdata = {24'h00_0000, st_reg.type_b_f_option_settings_reg};
          2'h1: st_next.rdata = {24'h00_0000, st_reg.stream_mode_definition_reg};
          default: st_next.rdata = {24'h00_0000, st_reg.auxiliary_definition_reg};
        endcase
      end
    end

    // modulation preset lands first so a bus write in the same cycle wins
    if (i_preset_valid) begin
      st_next.auxiliary_definition_reg[`NFO_AUX_MOD_AM] = i_preset_am;
    end

    // data phase: store the low byte of the word
    if (st_reg.wr_pend) begin
      case (st_reg.wr_sel)
        2'h0: st_next.type_b_f_option_settings_reg = wbyte;
        2'h1: st_next.stream_mode_definition_reg = wbyte & `NFO_ST_USED_MASK;
        default: st_next.auxiliary_definition_reg = wbyte;
      endcase
    end

    // set-default beats a write whose data phase falls in the same cycle
    if (i_set_default) begin
      st_next.type_b_f_option_settings_reg = `NFO_RST_TYPE_B_F;
      st_next.stream_mode_definition_reg = `NFO_RST_STREAM;
      st_next.auxiliary_definition_reg = `NFO_RST_AUX;
    end

    // receive side, from the rx frame copy
    tr1 = tr1_decode(bf_rx[`NFO_BF_TR1_HI:`NFO_BF_TR1_LO], i_evt.rate);
    st_next.cfg.min_tr1_fs = tr1[6:0];
    st_next.cfg.tr1_bad = tr1[7];
    st_next.cfg.accept_no_sof = bf_rx[`NFO_BF_NO_SOF];
    st_next.cfg.accept_no_eof = bf_rx[`NFO_BF_NO_EOF];
    // one sub-carrier period per bit cannot tell 11 from 12 etu
    if (i_evt.rate == NFO_RATE_FC16) begin
      st_next.cfg.eof_max_etu = `NFO_EOF_EXT_ETU;
    end else begin
      st_next.cfg.eof_max_etu = bf_rx[`NFO_BF_EOF_EXT] ? `NFO_EOF_EXT_ETU
        : `NFO_EOF_STD_ETU;
    end
    st_next.cfg.phase_tol_wide = bf_rx[`NFO_BF_PHASE_TOL];
    st_next.cfg.rx_crc_check = ~(aux_rx[`NFO_AUX_NO_CRC] | rx_snap[0]);
    st_next.cfg.crc_to_fifo = aux_rx[`NFO_AUX_CRC_FIFO];
    st_next.cfg.decoder_tolerant = aux_rx[`NFO_AUX_RX_TOL];

    // stream mode, from the rx copy for reporting, tx copy for modulator
    sc_div = scf_decode(st_rx[`NFO_ST_SCF_HI:`NFO_ST_SCF_LO], i_evt.bpsk_mode);
    st_next.cfg.subcarrier_div = sc_div;
    scp = st_rx[`NFO_ST_SCP_HI:`NFO_ST_SCP_LO];
    st_next.cfg.report_pulses = 4'(4'h1 << scp);
    tx_div = stx_decode(st_tx[`NFO_ST_STX_HI:`NFO_ST_STX_LO]);
    st_next.cfg.tx_period_div = tx_div;
    st_next.cfg.stream_bad = (sc_div == 8'h00) | (tx_div == 8'h00)
      | ((scp == 2'h0) & ~i_evt.bpsk_mode);

    // transmit side, from the tx frame copy
    pre = tx_snap[23 - 7 + `NFO_BF_PRE_HI:23 - 7 + `NFO_BF_PRE_LO];
    st_next.cfg.preamble_len = 7'(`NFO_PRE_BASE + 7'(pre) * `NFO_PRE_STEP);
    st_next.cfg.mod_am = aux_tx[`NFO_AUX_MOD_AM];
    // only floats while an ook bit is actually on the air
    st_next.cfg.driver_hiz = aux_tx[`NFO_AUX_OOK_HIZ] & ~aux_tx[`NFO_AUX_MOD_AM]
      & i_evt.ook_active;

    // not frame bound: follow the live register
    st_next.cfg.field_detect_en = st_reg.auxiliary_definition_reg[`NFO_AUX_FD_EN];
    st_next.cfg.field_on_n =
      st_reg.auxiliary_definition_reg[`NFO_AUX_FON_HI:`NFO_AUX_FON_LO];
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      st_reg.type_b_f_option_settings_reg <= `NFO_RST_TYPE_B_F;
      st_reg.stream_mode_definition_reg <= `NFO_RST_STREAM;
      st_reg.auxiliary_definition_reg <= `NFO_RST_AUX;
      st_reg.wr_pend <= 1'b0;
      st_reg.wr_sel <= 2'h0;
      st_reg.ready <= 1'b1;
      st_reg.rdata <= 32'h0000_0000;
      st_reg.cfg <= '{min_tr1_fs: `NFO_TR1_LONG, eof_max_etu: `NFO_EOF_STD_ETU,
        preamble_len: `NFO_PRE_BASE, subcarrier_div: 8'h40, report_pulses: 4'h1,
        tx_period_div: 8'h80, stream_bad: 1'b1, rx_crc_check: 1'b1,
        decoder_tolerant: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_hrdata = st_reg.rdata;
  assign o_hreadyout = st_reg.ready;
  assign o_hresp = 1'b0;
  assign o_cfg = st_reg.cfg;

endmodule

// ===== src/nfo_regs_map.svh
// register offsets, field positions, reset values and decode figures
// for the framing option register bank; assumes no other map shares names
`ifndef NFO_REGS_MAP_SVH
`define NFO_REGS_MAP_SVH

// register indices; byte address on the bus is four times the index
`define NFO_IDX_TYPE_B_F 8'h07
`define NFO_IDX_STREAM 8'h08
`define NFO_IDX_AUX 8'h09

// reset values
`define NFO_RST_TYPE_B_F 8'h00
`define NFO_RST_STREAM 8'h00
`define NFO_RST_AUX 8'h04

// type-b / type-f option register fields
`define NFO_BF_TR1_HI 7
`define NFO_BF_TR1_LO 6
`define NFO_BF_NO_SOF 5
`define NFO_BF_NO_EOF 4
`define NFO_BF_EOF_EXT 3
`define NFO_BF_PHASE_TOL 2
`define NFO_BF_PRE_HI 1
`define NFO_BF_PRE_LO 0

// stream mode register fields; bit 7 is not implemented
`define NFO_ST_USED_MASK 8'h7f
`define NFO_ST_SCF_HI 6
`define NFO_ST_SCF_LO 5
`define NFO_ST_SCP_HI 4
`define NFO_ST_SCP_LO 3
`define NFO_ST_STX_HI 2
`define NFO_ST_STX_LO 0

// auxiliary register fields
`define NFO_AUX_NO_CRC 7
`define NFO_AUX_CRC_FIFO 6
`define NFO_AUX_MOD_AM 5
`define NFO_AUX_FD_EN 4
`define NFO_AUX_OOK_HIZ 3
`define NFO_AUX_RX_TOL 2
`define NFO_AUX_FON_HI 1
`define NFO_AUX_FON_LO 0

// decode figures, in sub-carrier periods, etu and bits
`define NFO_TR1_LONG 7'd80
`define NFO_TR1_MID 7'd64
`define NFO_TR1_SHORT 7'd32
`define NFO_EOF_STD_ETU 4'd11
`define NFO_EOF_EXT_ETU 4'd12
`define NFO_PRE_BASE 7'd48
`define NFO_PRE_STEP 7'd16

`endif

// ===== src/nfo_pkg.sv
// types shared by the framing option register bank, its port checker and its bench
// assumes the map header is on the include path
package nfo_pkg;

  // framer bit rate as seen by the receive and transmit framers
  typedef enum logic [1:0] {
    NFO_RATE_FC128,
    NFO_RATE_FC64,
    NFO_RATE_FC32,
    NFO_RATE_FC16
  } nfo_rate_t;

  // decoded settings handed to the framers and the analog front end
  typedef struct packed {
    logic [6:0] min_tr1_fs;
    logic tr1_bad;
    logic accept_no_sof;
    logic accept_no_eof;
    logic [3:0] eof_max_etu;
    logic phase_tol_wide;
    logic [6:0] preamble_len;
    logic [7:0] subcarrier_div;
    logic [3:0] report_pulses;
    logic [7:0] tx_period_div;
    logic stream_bad;
    logic rx_crc_check;
    logic crc_to_fifo;
    logic mod_am;
    logic field_detect_en;
    logic driver_hiz;
    logic decoder_tolerant;
    logic [1:0] field_on_n;
  } nfo_cfg_t;

  // framer events that steer decoding
  typedef struct packed {
    logic tx_frame_start;
    logic rx_frame_start;
    logic reqa_wupa_sent;
    logic anticoll_frame;
    logic bpsk_mode;
    logic ook_active;
    nfo_rate_t rate;
  } nfo_evt_t;

  typedef struct packed {
    logic [7:0] type_b_f_option_settings_reg;
    logic [7:0] stream_mode_definition_reg;
    logic [7:0] auxiliary_definition_reg;
    logic wr_pend;
    logic [1:0] wr_sel;
    logic ready;
    logic [31:0] rdata;
    nfo_cfg_t cfg;
  } nfo_state_t;

endpackage

// ===== src/nfo_frame_snap.sv
// holds a copy of option bits taken at the start of a frame
// assumes i_load is a one-cycle pulse on the system clock
`timescale 1ns/1ns
module nfo_frame_snap #(
  parameter int WIDTH = 24,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;

  // a write during a frame stays out of the copy until the next start
  always_comb begin
    hold_next = i_load ? i_data : hold_reg;
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hold_reg <= RESET_VAL;
    end else begin
      hold_reg <= hold_next;
    end
  end

  assign o_data = hold_reg;

endmodule

// ===== verification/nfo_host_model.sv
// host model: ahb-lite master giving single word transfers
// assumes one slave whose hreadyout is the bus hready
`timescale 1ns/1ns
module nfo_host_model (
  input wire logic i_clk_sys,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata
);
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0;
    o_htrans = 2'b00;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0;
  end

  // an idle cycle always separates transfers, so read-back sees the new value
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
    @(posedge i_clk_sys);
    o_hsel <= 1'b1;
    o_haddr <= a;
    o_htrans <= 2'b10;
    o_hwrite <= wr;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    o_hsel <= 1'b0;
    o_htrans <= 2'b00;
    // read data phase: bus not driven, so show a changing pattern
    o_hwdata <= wr ? d : ~o_hwdata;
    do @(posedge i_clk_sys); while (i_hready !== 1'b1);
    rd = i_hrdata;
  endtask
endmodule

// ===== verification/nfo_option_regs_asserts.sv
// port checker for the framing option bank
// assumes single word transfers and the bind at the foot of this file
`timescale 1ns/1ns
module nfo_option_regs_asserts
  import nfo_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hreadyout,
  input wire logic o_hresp,
  input wire logic i_set_default,
  input wire logic i_preset_valid,
  input wire logic i_preset_am,
  input wire nfo_pkg::nfo_evt_t i_evt,
  input wire nfo_pkg::nfo_cfg_t o_cfg
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  logic tk;
  assign tk = i_hsel && i_hready && i_htrans[1];

  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("hresp not okay");
  a_zero_wait: assert property (o_hreadyout == 1'b1)
    else $error("wait state seen");
  a_rdata_upper: assert property (o_hrdata[31:8] == 24'h0)
    else $error("rdata upper bits set");
  a_stream_bit7: assert property (tk && !i_hwrite && i_haddr == 32'h20 |=> !o_hrdata[7])
    else $error("stream bit 7 read as one");
  a_unmapped_zero: assert property (tk && !i_hwrite
    && !(i_haddr inside {32'h1c, 32'h20, 32'h24}) |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_fon_follows: assert property (tk && i_hwrite && i_haddr == 32'h24 ##1 !i_set_default [*2]
    |-> ##1 o_cfg.field_on_n == $past(i_hwdata[1:0], 2))
    else $error("field on count wrong");
  a_fd_follows: assert property (tk && i_hwrite && i_haddr == 32'h24 ##1 !i_set_default [*2]
    |-> ##1 o_cfg.field_detect_en == $past(i_hwdata[4], 2))
    else $error("field detect enable wrong");
  a_auto_crc_skip: assert property (i_evt.rx_frame_start
    && (i_evt.reqa_wupa_sent || i_evt.anticoll_frame) |-> ##2 !o_cfg.rx_crc_check)
    else $error("crc not skipped");
  a_eof_fast: assert property ((i_evt.rate == NFO_RATE_FC16) [*2]
    |-> ##1 o_cfg.eof_max_etu == 4'd12)
    else $error("eof limit at top rate");
  a_hiz_ook: assert property (o_cfg.driver_hiz
    |-> $past(i_evt.ook_active) && !o_cfg.mod_am)
    else $error("driver floated outside ook");
  a_default_live: assert property (i_set_default && !(tk && i_hwrite)
    |-> ##2 o_cfg.field_on_n == 2'd0 && !o_cfg.field_detect_en)
    else $error("live fields not defaulted");
endmodule

bind nfo_option_regs nfo_option_regs_asserts u_chk (.i_clk_sys, .i_rst_n, .i_hsel,
  .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata,
  .o_hreadyout, .o_hresp, .i_set_default, .i_preset_valid, .i_preset_am, .i_evt, .o_cfg);

// ===== verification/tb_top.sv
// self-checking bench for the framing option bank
// assumes the host model and the map header on the include path
`timescale 1ns/1ns
`include "nfo_regs_map.svh"
module tb_top;
  import nfo_pkg::*;
  localparam logic [31:0] A_BF = {22'h0, `NFO_IDX_TYPE_B_F, 2'b00};
  localparam logic [31:0] A_ST = {22'h0, `NFO_IDX_STREAM, 2'b00};
  localparam logic [31:0] A_AX = {22'h0, `NFO_IDX_AUX, 2'b00};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hready, hresp;
  logic set_def = 1'b0;
  logic pre_v = 1'b0;
  logic pre_am = 1'b0;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] bf, st, ax;
  nfo_evt_t evt = '0;
  nfo_cfg_t cfg;
  int n_mismatch = 0;
  int num_checks = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  nfo_host_model u_nfo_host_model (.i_clk_sys(clk), .i_hready(hready), .i_hrdata(hrdata),
    .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite),
    .o_hsize(hsize), .o_hwdata(hwdata));
  nfo_option_regs u_nfo_option_regs (.i_clk_sys(clk), .i_rst_n(rst_n), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_set_default(set_def), .i_preset_valid(pre_v),
    .i_preset_am(pre_am), .i_evt(evt), .o_cfg(cfg));

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    logic [31:0] x;
    u_nfo_host_model.xfer(1'b1, a, {24'h0, d}, x);
  endtask

  task automatic rd(input logic [31:0] a, input logic [7:0] e);
    logic [31:0] x;
    u_nfo_host_model.xfer(1'b0, a, 32'h0, x);
    chk("rdata", x, {24'h0, e});
    chk("hresp", hresp, 32'h0);
  endtask

  // both framers start together; settings are read two edges later
  task automatic frame();
    @(posedge clk);
    evt.tx_frame_start <= 1'b1;
    evt.rx_frame_start <= 1'b1;
    @(posedge clk);
    evt.tx_frame_start <= 1'b0;
    evt.rx_frame_start <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask

  function automatic logic [7:0] e_sc(logic [1:0] c, logic b);
    if (b) return (c == 2'd0) ? 8'd16 : 8'd0;
    return (c == 2'd3) ? 8'd0 : 8'd64 >> c;
  endfunction

  task automatic chk_cfg(input logic [7:0] f, input logic [7:0] s, input logic [7:0] x);
    logic b;
    b = evt.bpsk_mode;
    chk("tr1_bad", cfg.tr1_bad, f[7]);
    if (!f[7]) begin
      chk("tr1", cfg.min_tr1_fs, !f[6] ? 80 : evt.rate == NFO_RATE_FC128 ? 64 : 32);
    end
    chk("no_sof", cfg.accept_no_sof, f[5]);
    chk("no_eof", cfg.accept_no_eof, f[4]);
    chk("eof", cfg.eof_max_etu, (f[3] || evt.rate == NFO_RATE_FC16) ? 12 : 11);
    chk("phase", cfg.phase_tol_wide, f[2]);
    chk("pre", cfg.preamble_len, 48 + 16 * f[1:0]);
    chk("sc", cfg.subcarrier_div, e_sc(s[6:5], b));
    chk("rep", cfg.report_pulses, 1 << s[4:3]);
    chk("txp", cfg.tx_period_div, s[2] ? 0 : 128 >> s[1:0]);
    chk("sbad", cfg.stream_bad, !e_sc(s[6:5], b) || s[2] || (!s[4:3] && !b));
    b = !(x[7] || evt.reqa_wupa_sent || evt.anticoll_frame);
    chk("crc", cfg.rx_crc_check, b);
    chk("fifo", cfg.crc_to_fifo, x[6]);
    chk("am", cfg.mod_am, x[5]);
    chk("fd", cfg.field_detect_en, x[4]);
    chk("hiz", cfg.driver_hiz, x[3] && !x[5] && evt.ook_active);
    chk("tol", cfg.decoder_tolerant, x[2]);
    chk("fon", cfg.field_on_n, x[1:0]);
  endtask

  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    bf = 8'($urandom(13));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_cfg(8'h00, 8'h00, 8'h04);
    rd(A_BF, 8'h00);
    rd(A_ST, 8'h00);
    rd(A_AX, 8'h04);
    wr(32'h28, 8'hff);
    rd(32'h28, 8'h00);
    rd(32'h18, 8'h00);
    for (int i = 0; i < 40; i++) begin
      bf = 8'($urandom);
      st = 8'($urandom);
      ax = 8'($urandom);
      @(posedge clk);
      evt.rate <= nfo_rate_t'($urandom_range(3));
      evt.bpsk_mode <= 1'($urandom);
      evt.ook_active <= 1'($urandom);
      evt.reqa_wupa_sent <= 1'($urandom);
      evt.anticoll_frame <= 1'($urandom);
      wr(A_BF, bf);
      wr(A_ST, st);
      wr(A_AX, ax);
      rd(A_ST, st & 8'h7f);
      rd(A_AX, ax);
      frame();
      chk_cfg(bf, st, ax);
    end
    // a write between frames must not reach the frame copy
    wr(A_BF, bf ^ 8'h03);
    repeat (3) @(posedge clk);
    #1;
    chk("pre_hold", cfg.preamble_len, 48 + 16 * bf[1:0]);
    frame();
    chk_cfg(bf ^ 8'h03, st, ax);
    @(posedge clk);
    pre_am <= 1'b1;
    pre_v <= 1'b1;
    @(posedge clk);
    pre_v <= 1'b0;
    rd(A_AX, ax | 8'h20);
    frame();
    chk("am", cfg.mod_am, 1'b1);
    wr(A_AX, ax & 8'hdf);
    frame();
    chk("am", cfg.mod_am, 1'b0);
    wr(A_BF, 8'hff);
    wr(A_ST, 8'hff);
    @(posedge clk);
    set_def <= 1'b1;
    @(posedge clk);
    set_def <= 1'b0;
    frame();
    chk_cfg(8'h00, 8'h00, 8'h04);
    rd(A_BF, 8'h00);
    rd(A_ST, 8'h00);
    rd(A_AX, 8'h04);
    report_and_stop();
  end
endmodule
